// >>> hdl/atxps_regs.svh
// constants of the transceiver setup sequencer: own register map, device locations, values
// assumes inclusion by bare name from the package file and the testbench
// What this block does
// - serial audio to the transmitter is left-justified or I2S only, never TDM
// - every configuration pass opens by writing 00 to page-select location 7F
// - converter master: write 00 (left-justified) or 01 (I2S) to location 03
// - converter master: write 00 to location 04, slave-mode serial port default
// - write 64, 24 or 04 to location 07 for normal, double, quad speed
// - write 00 to location 08 to enable line driver and encoded-output buffer
// - write 01 to location 09 so channel status and user bits come from page 2
// - the last configuration write is 34 to location 01, powering port and transmitter
// - converter slave: write 08 (left-justified) or 09 (I2S) to location 03
// - converter slave: write 03, 01 or 00 to location 04 per speed
// - buffer loading only after the transmitter block has been powered up
// - hold transfers at 08, page 2, write buffers, page 0, release hold
// - normal, double and quad speed cover 8kHz to 216kHz rates
`ifndef ATXPS_REGS_SVH
`define ATXPS_REGS_SVH

`define ATXPS_OFF_CTRL       8'h00
`define ATXPS_OFF_CFG        8'h04
`define ATXPS_OFF_STATUS     8'h08
`define ATXPS_OFF_BUF_BASE   8'h0C
`define ATXPS_OFF_BUF_LEN    8'h10
`define ATXPS_OFF_BUF_DATA   8'h40
`define ATXPS_OFF_BUF_END    8'h7C

`define ATXPS_CTRL_GO_CFG    0
`define ATXPS_CTRL_GO_BUF    1
`define ATXPS_STAT_BUSY      0
`define ATXPS_STAT_POWERED   1
`define ATXPS_STAT_BUF_DONE  2
`define ATXPS_STAT_REFUSED   3
`define ATXPS_STAT_STEP_LO   8

`define ATXPS_CFG_RESET      4'h0
`define ATXPS_BUF_BASE_RESET 8'h00
`define ATXPS_BUF_LEN_RESET  5'h01
`define ATXPS_BUF_LEN_MAX    5'h10

`define ATXPS_SPD_NORMAL     2'h0
`define ATXPS_SPD_DOUBLE     2'h1
`define ATXPS_SPD_QUAD       2'h2

`define ATXPS_DEV_PAGE_SEL   8'h7F
`define ATXPS_DEV_POWER      8'h01
`define ATXPS_DEV_PORT_FMT   8'h03
`define ATXPS_DEV_PORT_CLK   8'h04
`define ATXPS_DEV_TX_CLK     8'h07
`define ATXPS_DEV_TX_CTRL    8'h08
`define ATXPS_DEV_TX_SRC     8'h09

`define ATXPS_VAL_PAGE0      8'h00
`define ATXPS_VAL_PAGE2      8'h02
`define ATXPS_VAL_FMT_SLV_LJ 8'h00
`define ATXPS_VAL_FMT_SLV_I2S 8'h01
`define ATXPS_VAL_FMT_MST_LJ 8'h08
`define ATXPS_VAL_FMT_MST_I2S 8'h09
`define ATXPS_VAL_PCLK_SLAVE 8'h00
`define ATXPS_VAL_PCLK_512   8'h03
`define ATXPS_VAL_PCLK_256   8'h01
`define ATXPS_VAL_PCLK_128   8'h00
`define ATXPS_VAL_TCLK_512   8'h64
`define ATXPS_VAL_TCLK_256   8'h24
`define ATXPS_VAL_TCLK_128   8'h04
`define ATXPS_VAL_TX_RUN     8'h00
`define ATXPS_VAL_TX_HOLD    8'h01
`define ATXPS_VAL_SRC_BUF    8'h01
`define ATXPS_VAL_POWER_UP   8'h34

`define ATXPS_CFG_LAST_STEP  4'h6

`endif

// >>> hdl/atxps_pkg.sv
// types of the transceiver setup sequencer
// assumes atxps_regs.svh on the include path
`include "atxps_regs.svh"
package atxps_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CFG,
    S_BUF_HOLD,
    S_BUF_PAGE2,
    S_BUF_DATA,
    S_BUF_PAGE0,
    S_BUF_RUN
  } atxps_state_t;

  typedef struct packed {
    logic [1:0] speed;
    logic       i2s;
    logic       conv_slave;
  } atxps_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } atxps_dev_wr_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } atxps_reg_wr_t;

  function automatic logic atxps_mapped(input logic [7:0] a);
    atxps_mapped = (a[1:0] == 2'h0) &&
                   ((a <= `ATXPS_OFF_BUF_LEN) ||
                    ((a >= `ATXPS_OFF_BUF_DATA) && (a <= `ATXPS_OFF_BUF_END)));
  endfunction

endpackage

// >>> hdl/atxps_axil_slave.sv
// AXI4-Lite slave front end of the setup sequencer
// assumes a master on aclk; read data is offered combinationally by the parent
module atxps_axil_slave
  import atxps_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output atxps_pkg::atxps_reg_wr_t reg_wr,
  output logic                     reg_wr_pulse,
  output logic [7:0]               rd_addr,
  input  wire logic [31:0]         rd_data
);
  import atxps_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic aw_held;
  logic w_held;
  logic rd_pend;

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready      <= 1'b1;
      wready       <= 1'b1;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      bvalid       <= 1'b0;
      bresp        <= RESP_OKAY;
      reg_wr       <= '0;
      reg_wr_pulse <= 1'b0;
    end else begin
      reg_wr_pulse <= 1'b0;
      if (awvalid && awready) begin
        reg_wr.addr <= awaddr;
        aw_held     <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        reg_wr.data <= wdata;
        reg_wr.strb <= wstrb;
        w_held      <= 1'b1;
        wready      <= 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
        bvalid       <= 1'b1;
        bresp        <= atxps_mapped(reg_wr.addr) ? RESP_OKAY : RESP_SLVERR;
        reg_wr_pulse <= atxps_mapped(reg_wr.addr);
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_addr <= 8'h00;
      rd_pend <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rd_addr <= araddr;
        arready <= 1'b0;
        rd_pend <= 1'b1;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= atxps_mapped(rd_addr) ? rd_data : 32'h0000_0000;
        rresp   <= atxps_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// >>> hdl/atxps_top.sv
// setup sequencer for an external audio transceiver: register writes over a write port
// assumes the transceiver control-bus bridge accepts one location/value pair per handshake
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
module atxps_top
  import atxps_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output atxps_pkg::atxps_dev_wr_t dev_wr,
  output logic                     dev_wr_valid,
  input  wire logic                dev_wr_ready
);
  import atxps_pkg::*;

  atxps_reg_wr_t reg_wr;
  logic          reg_wr_pulse;
  logic [7:0]    rd_addr;
  logic [31:0]   rd_data;

  atxps_cfg_t    cfg;
  atxps_cfg_t    cfg_lat;
  atxps_cfg_t    next_cfg_lat;
  logic [7:0]    buf_base;
  logic [7:0]    buf_base_lat;
  logic [7:0]    next_buf_base;
  logic [4:0]    buf_len;
  logic [4:0]    buf_len_lat;
  logic [4:0]    next_buf_len;
  logic [7:0]    buf_mem [16];
  logic          powered;
  logic          buf_done;
  logic          refused;

  atxps_state_t  state;
  atxps_state_t  next_state;
  logic [3:0]    step;
  logic [3:0]    next_step;
  logic          next_valid;

  logic          wr_lane0;
  logic          go_cfg;
  logic          go_buf;
  logic          start_cfg;
  logic          start_buf;
  logic          handshake;

  atxps_axil_slave u_axil (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .reg_wr       (reg_wr),
    .reg_wr_pulse (reg_wr_pulse),
    .rd_addr      (rd_addr),
    .rd_data      (rd_data)
  );

  // port clock divider in converter-slave mode
  function automatic logic [7:0] port_clk_div(input logic [1:0] spd);
    case (spd)
      `ATXPS_SPD_DOUBLE: port_clk_div = `ATXPS_VAL_PCLK_256;
      `ATXPS_SPD_QUAD:   port_clk_div = `ATXPS_VAL_PCLK_128;
      default:           port_clk_div = `ATXPS_VAL_PCLK_512;
    endcase
  endfunction

  function automatic logic [7:0] tx_clk_div(input logic [1:0] spd);
    case (spd)
      `ATXPS_SPD_DOUBLE: tx_clk_div = `ATXPS_VAL_TCLK_256;
      `ATXPS_SPD_QUAD:   tx_clk_div = `ATXPS_VAL_TCLK_128;
      default:           tx_clk_div = `ATXPS_VAL_TCLK_512;
    endcase
  endfunction

  function automatic atxps_dev_wr_t payload(input atxps_state_t st, input logic [3:0] idx,
                                            input atxps_cfg_t c, input logic [7:0] base,
                                            input logic [7:0] byte_val);
    atxps_dev_wr_t w;
    w = '0;
    case (st)
      S_CFG: begin
        case (idx)
          4'h0: begin
            w.addr = `ATXPS_DEV_PAGE_SEL;
            w.data = `ATXPS_VAL_PAGE0;
          end
          4'h1: begin
            w.addr = `ATXPS_DEV_PORT_FMT;
            if (c.conv_slave) begin
              w.data = c.i2s ? `ATXPS_VAL_FMT_MST_I2S : `ATXPS_VAL_FMT_MST_LJ;
            end else begin
              w.data = c.i2s ? `ATXPS_VAL_FMT_SLV_I2S : `ATXPS_VAL_FMT_SLV_LJ;
            end
          end
          4'h2: begin
            w.addr = `ATXPS_DEV_PORT_CLK;
            w.data = c.conv_slave ? port_clk_div(c.speed) : `ATXPS_VAL_PCLK_SLAVE;
          end
          4'h3: begin
            w.addr = `ATXPS_DEV_TX_CLK;
            w.data = tx_clk_div(c.speed);
          end
          4'h4: begin
            w.addr = `ATXPS_DEV_TX_CTRL;
            w.data = `ATXPS_VAL_TX_RUN;
          end
          4'h5: begin
            w.addr = `ATXPS_DEV_TX_SRC;
            w.data = `ATXPS_VAL_SRC_BUF;
          end
          default: begin
            w.addr = `ATXPS_DEV_POWER;
            w.data = `ATXPS_VAL_POWER_UP;
          end
        endcase
      end
      S_BUF_HOLD: begin
        w.addr = `ATXPS_DEV_TX_CTRL;
        w.data = `ATXPS_VAL_TX_HOLD;
      end
      S_BUF_PAGE2: begin
        w.addr = `ATXPS_DEV_PAGE_SEL;
        w.data = `ATXPS_VAL_PAGE2;
      end
      S_BUF_DATA: begin
        w.addr = base + {4'h0, idx};
        w.data = byte_val;
      end
      S_BUF_PAGE0: begin
        w.addr = `ATXPS_DEV_PAGE_SEL;
        w.data = `ATXPS_VAL_PAGE0;
      end
      S_BUF_RUN: begin
        w.addr = `ATXPS_DEV_TX_CTRL;
        w.data = `ATXPS_VAL_TX_RUN;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  // register decode
  assign wr_lane0  = reg_wr_pulse && reg_wr.strb[0];
  assign go_cfg    = wr_lane0 && (reg_wr.addr == `ATXPS_OFF_CTRL) &&
                     reg_wr.data[`ATXPS_CTRL_GO_CFG];
  assign go_buf    = wr_lane0 && (reg_wr.addr == `ATXPS_OFF_CTRL) &&
                     reg_wr.data[`ATXPS_CTRL_GO_BUF];
  // reserved speed code refused so every divider write uses one valid speed
  assign start_cfg = go_cfg && (state == S_IDLE) && (cfg.speed != 2'h3);
  assign start_buf = go_buf && !go_cfg && (state == S_IDLE) && powered &&
                     (buf_len != 5'h00) && (buf_len <= `ATXPS_BUF_LEN_MAX);
  assign handshake = dev_wr_valid && dev_wr_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg      <= `ATXPS_CFG_RESET;
      buf_base <= `ATXPS_BUF_BASE_RESET;
      buf_len  <= `ATXPS_BUF_LEN_RESET;
    end else if (wr_lane0) begin
      case (reg_wr.addr)
        `ATXPS_OFF_CFG:      cfg      <= reg_wr.data[3:0];
        `ATXPS_OFF_BUF_BASE: buf_base <= reg_wr.data[7:0];
        `ATXPS_OFF_BUF_LEN:  buf_len  <= reg_wr.data[4:0];
        default: ;
      endcase
    end
  end

  // buffer bytes frozen while a pass runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (wr_lane0 && (state == S_IDLE) && (reg_wr.addr >= `ATXPS_OFF_BUF_DATA)) begin
      buf_mem[reg_wr.addr[5:2]] <= reg_wr.data[7:0];
    end
  end

  // refusal flag: a new refusal wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused <= 1'b0;
    end else if ((go_cfg && !start_cfg) || (go_buf && !start_buf)) begin
      refused <= 1'b1;
    end else if (wr_lane0 && (reg_wr.addr == `ATXPS_OFF_STATUS) &&
                 reg_wr.data[`ATXPS_STAT_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered  <= 1'b0;
      buf_done <= 1'b0;
    end else begin
      if (start_cfg) begin
        powered  <= 1'b0;
        buf_done <= 1'b0;
      end else if (handshake && (state == S_CFG) && (step == `ATXPS_CFG_LAST_STEP)) begin
        powered <= 1'b1;
      end
      if (start_buf) begin
        buf_done <= 1'b0;
      end else if (handshake && (state == S_BUF_RUN)) begin
        buf_done <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `ATXPS_OFF_CFG:      rd_data[3:0] = cfg;
      `ATXPS_OFF_BUF_BASE: rd_data[7:0] = buf_base;
      `ATXPS_OFF_BUF_LEN:  rd_data[4:0] = buf_len;
      `ATXPS_OFF_STATUS: begin
        rd_data[`ATXPS_STAT_BUSY]     = (state != S_IDLE);
        rd_data[`ATXPS_STAT_POWERED]  = powered;
        rd_data[`ATXPS_STAT_BUF_DONE] = buf_done;
        rd_data[`ATXPS_STAT_REFUSED]  = refused;
        rd_data[`ATXPS_STAT_STEP_LO +: 4] = step;
      end
      default: begin
        if (rd_addr >= `ATXPS_OFF_BUF_DATA) begin
          rd_data[7:0] = buf_mem[rd_addr[5:2]];
        end
      end
    endcase
  end

  // snapshot taken at start so one pass uses one setting throughout
  always_comb begin
    next_cfg_lat  = start_cfg ? cfg : cfg_lat;
    next_buf_base = start_buf ? buf_base : buf_base_lat;
    next_buf_len  = start_buf ? buf_len : buf_len_lat;
  end

  // one write outstanding; advance only on its handshake
  always_comb begin
    next_state = state;
    next_step  = step;
    next_valid = dev_wr_valid;
    if (state == S_IDLE) begin
      if (start_cfg) begin
        next_state = S_CFG;
        next_step  = 4'h0;
        next_valid = 1'b1;
      end else if (start_buf) begin
        next_state = S_BUF_HOLD;
        next_step  = 4'h0;
        next_valid = 1'b1;
      end
    end else if (handshake) begin
      case (state)
        S_CFG: begin
          if (step == `ATXPS_CFG_LAST_STEP) begin
            next_state = S_IDLE;
            next_valid = 1'b0;
          end else begin
            next_step = step + 4'h1;
          end
        end
        S_BUF_HOLD:  next_state = S_BUF_PAGE2;
        S_BUF_PAGE2: begin
          next_state = S_BUF_DATA;
          next_step  = 4'h0;
        end
        S_BUF_DATA: begin
          if (({1'b0, step} + 5'h01) == buf_len_lat) begin
            next_state = S_BUF_PAGE0;
          end else begin
            next_step = step + 4'h1;
          end
        end
        S_BUF_PAGE0: next_state = S_BUF_RUN;
        S_BUF_RUN: begin
          next_state = S_IDLE;
          next_valid = 1'b0;
        end
        default: begin
          next_state = S_IDLE;
          next_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= S_IDLE;
      step         <= 4'h0;
      cfg_lat      <= `ATXPS_CFG_RESET;
      buf_base_lat <= `ATXPS_BUF_BASE_RESET;
      buf_len_lat  <= `ATXPS_BUF_LEN_RESET;
      dev_wr_valid <= 1'b0;
      dev_wr       <= '0;
    end else begin
      state        <= next_state;
      step         <= next_step;
      cfg_lat      <= next_cfg_lat;
      buf_base_lat <= next_buf_base;
      buf_len_lat  <= next_buf_len;
      dev_wr_valid <= next_valid;
      if (next_valid && (!dev_wr_valid || handshake)) begin
        dev_wr <= payload(next_state, next_step, next_cfg_lat, next_buf_base,
                          buf_mem[next_step]);
      end
    end
  end

  a_stall_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_wr_valid && !dev_wr_ready |=> dev_wr_valid && $stable(dev_wr))
    else $error("write payload changed while stalled");

  a_opens_page0: assert property (@(posedge aclk) disable iff (!aresetn)
    start_cfg |=> dev_wr_valid && dev_wr.addr == 8'h7F && dev_wr.data == 8'h00)
    else $error("configuration did not open with page 0 select");

  a_master_fmt: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && dev_wr.addr == 8'h03 && !cfg_lat.conv_slave
    |-> dev_wr.data == {7'h00, cfg_lat.i2s})
    else $error("wrong slave-port format value");

  a_slave_fmt: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && dev_wr.addr == 8'h03 && cfg_lat.conv_slave
    |-> dev_wr.data == {7'h04, cfg_lat.i2s})
    else $error("wrong master-port format value");

  a_port_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && dev_wr.addr == 8'h04
    |-> dev_wr.data == (!cfg_lat.conv_slave ? 8'h00 :
                        cfg_lat.speed == 2'h0 ? 8'h03 : cfg_lat.speed == 2'h1 ? 8'h01 : 8'h00))
    else $error("wrong port clock divider");

  a_tx_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && dev_wr.addr == 8'h07
    |-> dev_wr.data == (cfg_lat.speed == 2'h0 ? 8'h64 : cfg_lat.speed == 2'h1 ? 8'h24 : 8'h04))
    else $error("wrong transmitter clock divider");

  a_line_src: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && step == 4'h4 |=> dev_wr.addr == 8'h09 && dev_wr.data == 8'h01)
    else $error("line enable not followed by buffer source select");

  a_power_last: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_CFG && dev_wr.addr == 8'h01
    |-> dev_wr.data == 8'h34 ##1 (state == S_IDLE && powered && !dev_wr_valid))
    else $error("power-up not the final configuration write");

  a_buf_powered: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == S_BUF_HOLD) |-> powered && dev_wr.addr == 8'h08 && dev_wr.data == 8'h01)
    else $error("buffer load without powered transmitter");

  a_buf_release: assert property (@(posedge aclk) disable iff (!aresetn)
    handshake && state == S_BUF_PAGE0
    |-> dev_wr.data == 8'h00 ##1 (dev_wr.addr == 8'h08 && dev_wr.data == 8'h00))
    else $error("hold not released after page 0 reselect");

endmodule

// >>> sim/atxps_dev_model.sv
// behavioural transceiver control port: takes location/value pairs and logs them
// assumes the sequencer's write port on aclk; slow stretches ready to 1 cycle in 8
module atxps_dev_model (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire atxps_pkg::atxps_dev_wr_t dev_wr,
  input  wire logic                     dev_wr_valid,
  output logic                          dev_wr_ready,
  input  wire logic                     slow
);
  timeunit 1ns;
  timeprecision 1ps;
  import atxps_pkg::*;
  logic [15:0] log_q [0:255];
  int          n_log;
  logic [7:0]  page;
  logic [2:0]  cnt;
  assign dev_wr_ready = !slow || (cnt == 3'h7);
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_log <= 0;
      page  <= 8'h00;
    end else if (dev_wr_valid && dev_wr_ready) begin
      log_q[n_log[7:0]] <= dev_wr;
      n_log <= n_log + 1;
      if (dev_wr.addr == 8'h7F) page <= dev_wr.data;
    end
  end
endmodule

// >>> sim/tb.sv
// self-checking bench of the transceiver setup sequencer
// assumes atxps_regs.svh on the include path and the transceiver model beside it
`include "atxps_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atxps_pkg::*;
  logic          aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, seed = 32'h12FE;
  logic [3:0]    wstrb = 4'h0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, dev_wr_valid, dev_wr_ready;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata;
  atxps_dev_wr_t dev_wr;
  logic [7:0]    bufv [0:15];
  int            n_errors = 0, checked = 0;
  always #12.5 aclk = ~aclk;
  atxps_top i_atxps_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dev_wr(dev_wr), .dev_wr_valid(dev_wr_valid), .dev_wr_ready(dev_wr_ready));
  atxps_dev_model i_atxps_dev_model (.aclk(aclk), .aresetn(aresetn), .dev_wr(dev_wr),
    .dev_wr_valid(dev_wr_valid), .dev_wr_ready(dev_wr_ready), .slow(slow));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] got(input int j);
    return i_atxps_dev_model.log_q[j];
  endfunction
  function automatic logic [15:0] exp_cfg(input logic [3:0] c, input int k);
    logic [7:0] tclk;
    logic [7:0] pclk;
    tclk = (c[3:2] == 2'h0) ? 8'h64 : (c[3:2] == 2'h1) ? 8'h24 : 8'h04;
    pclk = !c[0] ? 8'h00 : (c[3:2] == 2'h0) ? 8'h03 : (c[3:2] == 2'h1) ? 8'h01 : 8'h00;
    case (k)
      0: return 16'h7F00;
      1: return {8'h03, 4'h0, c[0], 2'h0, c[1]};
      2: return {8'h04, pclk};
      3: return {8'h07, tclk};
      4: return 16'h0800;
      5: return 16'h0901;
      default: return 16'h0134;
    endcase
  endfunction
  function automatic logic [15:0] exp_buf(input logic [7:0] b, input int n, input int k);
    if (k == 0) return 16'h0801;
    if (k == 1) return 16'h7F02;
    if (k < n + 2) return {b + 8'(k - 2), bufv[k - 2]};
    if (k == n + 2) return 16'h7F00;
    return 16'h0800;
  endfunction
  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    close_out();
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 100) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 100) tmo();
  endtask
  task automatic wait_idle(output logic [31:0] d);
    logic [1:0] r;
    int         i;
    for (i = 0; i < 300; i++) begin
      axi_rd(`ATXPS_OFF_STATUS, d, r);
      if (d[0] === 1'b0) break;
    end
    if (i == 300) tmo();
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  base;
    int          n0, len;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`ATXPS_OFF_CFG, d, r);
    cmp32(d, 32'h0);
    axi_rd(`ATXPS_OFF_BUF_LEN, d, r);
    cmp32(d, 32'h1);
    axi_rd(8'h20, d, r);
    cmp32({d[29:0], r}, 32'h2);
    axi_wr(8'h22, 32'h1, r);
    cmp32({30'h0, r}, 32'h2);
    // buffer load before power-up and an undefined speed are both refused
    axi_wr(`ATXPS_OFF_CTRL, 32'h2, r);
    wait_idle(d);
    cmp32(d & 32'hF, 32'h8);
    axi_wr(`ATXPS_OFF_STATUS, 32'h8, r);
    cmp32({30'h0, r}, 32'h0);
    axi_wr(`ATXPS_OFF_CFG, 32'hC, r);
    axi_wr(`ATXPS_OFF_CTRL, 32'h1, r);
    wait_idle(d);
    cmp32(d & 32'hF, 32'h8);
    cmp32(i_atxps_dev_model.n_log, 32'h0);
    // clear the refusal so the buffer status checks see it low
    axi_wr(`ATXPS_OFF_STATUS, 32'h8, r);
    for (int k = 0; k < 12; k++) begin
      d = rnd();
      slow <= d[0];
      n0 = i_atxps_dev_model.n_log;
      axi_wr(`ATXPS_OFF_CFG, 32'(k), r);
      axi_wr(`ATXPS_OFF_CTRL, 32'h1, r);
      wait_idle(d);
      cmp32(d & 32'h3, 32'h2);
      cmp32(i_atxps_dev_model.n_log - n0, 32'h7);
      for (int j = 0; j < 7; j++) begin
        cmp16(got(n0 + j), exp_cfg(4'(k), j));
      end
    end
    // shortest, longest and a random buffer load, base wrapping allowed
    for (int p = 0; p < 3; p++) begin
      d = rnd();
      slow <= d[1];
      base = d[15:8];
      len = (p == 0) ? 1 : (p == 1) ? 16 : int'(d[19:16]) + 1;
      for (int i = 0; i < 16; i++) begin
        d = rnd();
        bufv[i] = d[7:0];
        axi_wr(8'(`ATXPS_OFF_BUF_DATA + 4 * i), d, r);
      end
      axi_wr(`ATXPS_OFF_BUF_BASE, {24'h0, base}, r);
      axi_wr(`ATXPS_OFF_BUF_LEN, 32'(len), r);
      n0 = i_atxps_dev_model.n_log;
      axi_wr(`ATXPS_OFF_CTRL, 32'h2, r);
      wait_idle(d);
      cmp32(d & 32'hD, 32'h4);
      cmp32(i_atxps_dev_model.n_log - n0, 32'(len + 4));
      cmp32({24'h0, i_atxps_dev_model.page}, 32'h0);
      for (int j = 0; j < len + 4; j++) begin
        cmp16(got(n0 + j), exp_buf(base, len, j));
      end
    end
    close_out();
  end
endmodule
